// [rtl/serial_dac_write_port.v]
// Overview of operation
// - Low frame sync opens a frame and enables the shift register.
// - Each of the first sixteen serial clock falling edges in a frame shifts one data bit in.
// - Sixteenth falling edge loads code and power mode from the word.
// - Frame sync rising before sixteenth edge discards the frame entirely.
// - First two shifted bits select normal or one of three power-down modes.
// - Next eight bits are the binary code; trailing bits are ignored.
// - Reset clears the code register until a valid full frame.
`timescale 1ns/100ps
`default_nettype none
`include "serial_dac_defs.vh"
module serial_dac_write_port (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sync_n_in,
  input wire sclk_in,
  input wire din_in,
  output reg [7:0] dac_code_out,
  output reg power_mode_bit1_out,
  output reg power_mode_bit0_out,
  output reg update_out
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire sync_n_s;
  wire sclk_s;
  wire din_s;
  sync_2ff #(.RST_VAL(1'b1)) u_sync_fs (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(sync_n_in),
    .q_out(sync_n_s)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_ck (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(sclk_in),
    .q_out(sclk_s)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_di (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(din_in),
    .q_out(din_s)
  );
  // ------------------------------------------------------------
  // Edge detect
  // ------------------------------------------------------------
  // Data passes the same two stages as the clock, so it is sampled
  // aligned with the falling edge seen here. Link clock above about
  // 25 MHz cannot be resolved by a 100 MHz sampler.
  reg sclk_q;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk_s;
  end
  wire sclk_fall = sclk_q & ~sclk_s;
  // ------------------------------------------------------------
  // Shift and count
  // ------------------------------------------------------------
  reg [`WORD_BITS-1:0] shift_q;
  reg [`CNT_W-1:0] cnt_q;
  wire [`WORD_BITS-1:0] word_d = {shift_q[`WORD_BITS-2:0], din_s};
  wire last_bit = (cnt_q == `CNT_LAST);
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_q <= `WORD_RST;
      cnt_q <= `CNT_RST;
    end
    else if (sync_n_s)
    begin
      shift_q <= `WORD_RST;
      cnt_q <= `CNT_RST;
    end
    else if (sclk_fall && (cnt_q < `CNT_FULL))
    begin
      shift_q <= word_d;
      cnt_q <= cnt_q + `CNT_INC;
    end
  end
  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  wire load = ~sync_n_s & sclk_fall & last_bit;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dac_code_out <= `CODE_RST;
      power_mode_bit1_out <= 1'b0;
      power_mode_bit0_out <= 1'b0;
      update_out <= 1'b0;
    end
    else
    begin
      update_out <= load;
      if (load)
      begin
        power_mode_bit1_out <= word_d[`MODE_HI];
        power_mode_bit0_out <= word_d[`MODE_LO];
        dac_code_out <= word_d[`CODE_HI:`CODE_LO];
      end
    end
  end
endmodule // serial_dac_write_port
`default_nettype wire

// [rtl/serial_dac_defs.vh]
`ifndef SERIAL_DAC_DEFS_VH
`define SERIAL_DAC_DEFS_VH
// Frame geometry
`define WORD_BITS 16
`define CNT_W 5
`define MODE_HI 15
`define MODE_LO 14
`define CODE_HI 13
`define CODE_LO 6
`define CODE_W 8
`define MODE_W 2
// Reset values
`define CODE_RST 8'h00
`define MODE_RST 2'h0
`define CNT_RST 5'h00
`define WORD_RST 16'h0000
// Counter end points and increment
`define CNT_LAST 5'h0f
`define CNT_FULL 5'h10
`define CNT_INC 5'h01
`endif

// [rtl/sync_2ff.v]
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter RST_VAL = 1'b0
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire d_in,
  output reg q_out
);
  reg meta_q;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// [sim/serial_dac_write_port_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_dac_write_port_asserts (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sync_n_in,
  input wire [7:0] dac_code_out,
  input wire power_mode_bit1_out,
  input wire power_mode_bit0_out,
  input wire update_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  upd_pulse_a: assert property (update_out |=> !update_out)
    else $error("update too long");
  out_hold_a: assert property (!update_out |->
    $stable({dac_code_out, power_mode_bit1_out, power_mode_bit0_out})) else $error("output moved");
  in_frame_a: assert property ($rose(update_out) |-> $past(!sync_n_in, 8))
    else $error("update outside frame");
  // update only if frame sync was low four cycles earlier
  late_frame_a: assert property ($rose(update_out) |-> $past(!sync_n_in, 4))
    else $error("update after frame sync rose");
  reset_zero_a: assert property ($fell(rst_in) |->
    ({dac_code_out, power_mode_bit1_out, power_mode_bit0_out, update_out} == 11'h000))
    else $error("outputs not zero after reset");
  upd_gap_a: assert property (update_out |=> (!update_out)[*8])
    else $error("updates too close");
endmodule // serial_dac_write_port_asserts
bind serial_dac_write_port serial_dac_write_port_asserts u_chk (.*);
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output logic sync_n_out = 1'b1,
  output logic sclk_out = 1'b1,
  output logic din_out = 1'b0
);
  // 125 ns link period, far below the limit
  task frame(input logic [15:0] w, input int n);
    sync_n_out = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      din_out = w[i];
      #62.5 sclk_out = 1'b0;
      #62.5 sclk_out = 1'b1;
    end
    #62.5 sync_n_out = 1'b1;
    din_out = ~din_out;
    #200;
  endtask
endmodule // host_model
`default_nettype wire

// [sim/serial_dac_write_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_dac_write_port_test;
  logic ref_clk_in = 1'b0, rst_in = 1'b1;
  wire sync_n, sclk, din, pm1, pm0, upd;
  wire [7:0] code;
  int n_errors = 0, samples_checked = 0, seed = 62, cyc = 0, n_upd = 0;
  logic [9:0] exp_q = 10'h000;
  logic [15:0] w;
  always #5 ref_clk_in = ~ref_clk_in;
  host_model host_model_inst (.sync_n_out(sync_n), .sclk_out(sclk), .din_out(din));
  serial_dac_write_port serial_dac_write_port_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .sync_n_in(sync_n), .sclk_in(sclk), .din_in(din), .dac_code_out(code),
    .power_mode_bit1_out(pm1), .power_mode_bit0_out(pm0), .update_out(upd));
  task chk(input logic [9:0] s, input logic [9:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) if (++cyc == 20000) begin n_errors++; results; end
  always @(negedge ref_clk_in) if (upd === 1'b1) begin n_upd++; chk({pm1, pm0, code}, exp_q); end
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    chk({pm1, pm0, code}, 10'h000);
    for (int i = 0; i < 8; i++)
    begin
      w = {i[1:0], 14'($random(seed))};
      exp_q = w[15:6];
      host_model_inst.frame(w, 16);
      chk(10'(n_upd), 10'(i + 1));
      host_model_inst.frame(~w, 4 + i);
      chk({pm1, pm0, code}, exp_q);
      chk(10'(n_upd), 10'(i + 1));
      $display("frame pair %0d done", i);
    end
    results;
  end
endmodule // serial_dac_write_port_test
`default_nettype wire
